/* src/pass_defs.vh */
// constants for the printer adapter: register map, status fields, timing
// assumes a 20 MHz clock and a 32-bit classic wishbone register port
`ifndef PASS_DEFS_VH
`define PASS_DEFS_VH

// register byte offsets
`define PASS_SEL_OFS 8'h00
`define PASS_CMD_OFS 8'h04
`define PASS_DATA_OFS 8'h08
`define PASS_STAT_OFS 8'h0C
`define PASS_CFG_OFS 8'h10
`define PASS_IRQ_STAT_OFS 8'h14
`define PASS_IRQ_MASK_OFS 8'h18

// command register bits (write one to issue; bit 2 holds the irq enable)
`define PASS_CMD_INIT 0
`define PASS_CMD_DEV_CLEAR 1
`define PASS_CMD_IEN 2

// read_status_flags bit positions
`define PASS_ST_NOT_BUSY 7
`define PASS_ST_PR_SEL 6
`define PASS_ST_NOT_READY 1
`define PASS_ST_PR_BUSY 0

// interrupt status bits
`define PASS_EV_NOT_BUSY 0
`define PASS_EV_PR_DESEL 1

// reset values
`define PASS_OWN_ADDR_RST 8'h1D
`define PASS_SLOT_RST 4'h7
`define PASS_OPEN_BUS 8'hFF

// slot to priority mapping
`define PASS_SLOT_MIN 4'h7
`define PASS_SLOT_MAX 4'hA
`define PASS_SLOT_TO_PRIO 4'h4
`define PASS_PRIO_MAIN 3'h3

// minimum bits high in a select address that can reach the adapter
`define PASS_SEL_MIN_ONES 4

// timing: figures in ns, counts rounded up to whole cycles
`define PASS_CLK_NS 50
`define PASS_SETUP_NS 500
`define PASS_STB_NS 1000
`define PASS_HOLD_NS 5000
`define PASS_SETUP_CYC ((`PASS_SETUP_NS + `PASS_CLK_NS - 1) / `PASS_CLK_NS)
`define PASS_STB_CYC ((`PASS_STB_NS + `PASS_CLK_NS - 1) / `PASS_CLK_NS)
`define PASS_HOLD_CYC ((`PASS_HOLD_NS + `PASS_CLK_NS - 1) / `PASS_CLK_NS)

`endif

/* src/pass_sel_decode.v */
// select address decoder: compares an issued select byte to the own address
// assumes both bytes are stable in the cycle they are sampled
`timescale 1ns/1ps
`include "pass_defs.vh"

module pass_sel_decode #(
    parameter WIDTH = 8
) (
    input wire [WIDTH-1:0] issued_i,
    input wire [WIDTH-1:0] own_i,
    output wire match_o
);
    wire [3:0] ones [0:WIDTH]; // running count of high address bits

    assign ones[0] = 4'h0;

    // count the high bits of the issued byte
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_cnt
            assign ones[g+1] = ones[g] + {3'h0, issued_i[g]};
        end
    endgenerate

    // acts like a four-input and gate: bytes with three or fewer ones never match
    assign match_o = (ones[WIDTH] >= `PASS_SEL_MIN_ONES) && (issued_i == own_i);

endmodule // pass_sel_decode

/* src/pass_strobe_gen.v */
// character strobe sequencer toward the printer: setup, strobe, accept hold
// assumes start_i is a one-cycle pulse issued only while idle
`timescale 1ns/1ps
`include "pass_defs.vh"

module pass_strobe_gen #(
    parameter SETUP_CYC = `PASS_SETUP_CYC,
    parameter STB_CYC = `PASS_STB_CYC,
    parameter HOLD_CYC = `PASS_HOLD_CYC
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire start_i,
    input wire abort_i,
    input wire [7:0] char_i,
    output wire [7:0] pr_data_o,
    output wire pr_strobe_n_o,
    output wire active_o
);
    localparam S_IDLE = 4'b0001;
    localparam S_SETUP = 4'b0010;
    localparam S_STB = 4'b0100;
    localparam S_HOLD = 4'b1000;

    reg [3:0] state_reg; // sequencer state
    reg [3:0] state_next;
    reg [15:0] cnt_reg; // cycles left in the phase
    reg [15:0] cnt_next;
    reg [7:0] data_reg; // character on the pins
    reg stb_n_reg; // registered strobe, glitch free

    // next state; abort wins so an init never leaves a strobe half done
    always @* begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        if (cnt_reg != 16'h0000) begin
            cnt_next = cnt_reg - 16'h0001;
        end
        case (state_reg)
            S_IDLE: begin
                if (start_i) begin
                    state_next = S_SETUP;
                    cnt_next = SETUP_CYC[15:0] - 16'h0001;
                end
            end
            S_SETUP: begin
                if (cnt_reg == 16'h0000) begin
                    state_next = S_STB;
                    cnt_next = STB_CYC[15:0] - 16'h0001;
                end
            end
            S_STB: begin
                if (cnt_reg == 16'h0000) begin
                    state_next = S_HOLD;
                    cnt_next = HOLD_CYC[15:0] - 16'h0001;
                end
            end
            S_HOLD: begin
                if (cnt_reg == 16'h0000) begin
                    state_next = S_IDLE;
                end
            end
            default: begin
                state_next = S_IDLE;
                cnt_next = 16'h0000;
            end
        endcase
        if (abort_i) begin
            state_next = S_IDLE;
            cnt_next = 16'h0000;
        end
    end

    // state, data and strobe registers
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= S_IDLE;
            cnt_reg <= 16'h0000;
            data_reg <= 8'h00;
            stb_n_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            stb_n_reg <= (state_next != S_STB);
            if (start_i && (state_reg == S_IDLE)) begin
                data_reg <= char_i;
            end
        end
    end

    assign pr_data_o = data_reg;
    assign pr_strobe_n_o = stb_n_reg;
    assign active_o = (state_reg != S_IDLE);

endmodule // pass_strobe_gen

/* src/pass_adapter.v */
// printer adapter core: select decode, character output, status flags, irq
// assumes a classic wishbone master and printer pins synchronous to clk_i
`timescale 1ns/1ps
`include "pass_defs.vh"

// register word map, data in the low bits of each 32-bit word:
//   0x00 select: write the issued select byte, read bit 0 = selected
//   0x04 command: bit 0 initialise, bit 1 device clear, bit 2 irq enable
//   0x08 data: one character toward the printer
//   0x0C status flags: not-busy, printer selected, not ready, printer busy
//   0x10 config: own select address in [7:0], slot number in [11:8]
//   0x14 irq status: write one to clear a sticky event
//   0x18 irq mask: same layout as irq status
// every access is answered one cycle after it is taken, unmapped ones too,
// so a master never needs a timeout on this port
// writes take effect on the edge that ack is sampled high, never earlier,
// so an aborted cycle leaves the registers untouched
// the enable bit is rewritten by every command write: software that
// issues a clear has to set it again in the same word to keep interrupts
// a character is taken only while selected and not busy; a second one
// written too early is dropped, as there is no queue behind the pins
// an unselected adapter reads its status as an open bus, all ones, so
// software can tell a missing board from a busy printer
// the priority level is registered, so it settles one cycle after the
// slot field changes

module pass_adapter #(
    parameter SETUP_CYC = `PASS_SETUP_CYC,
    parameter STB_CYC = `PASS_STB_CYC,
    parameter HOLD_CYC = `PASS_HOLD_CYC
) (
    input wire clk_i,
    input wire rst_n_i,
    // register port, classic wishbone
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire wb_ack_o,
    // printer side
    input wire pr_busy_i,
    input wire pr_ready_i,
    input wire pr_selected_i,
    output wire [7:0] pr_data_o,
    output wire pr_strobe_n_o,
    output wire pr_init_n_o,
    // interrupt request toward the host
    output wire irq_o,
    output wire [2:0] irq_level_o
);
    // architectural state; reset returns all of it to the initialise values
    reg ack_reg; // one-cycle bus answer
    reg [31:0] rdat_reg; // read data captured with ack
    reg selected_reg; // adapter currently selected
    reg not_busy_reg; // ready for another character
    reg pr_busy_reg; // printer busy flag
    reg pending_reg; // character handed to the printer, not yet accepted
    reg ien_reg; // global interrupt enable
    reg [7:0] own_addr_reg; // programmable select address
    reg [3:0] slot_reg; // slot number the board sits in
    reg [2:0] level_reg; // interrupt priority driven out
    reg [1:0] irq_stat_reg; // sticky events
    reg [1:0] irq_mask_reg; // event enables
    reg pr_sel_reg; // last printer select level, edge detect
    reg init_n_reg; // clear pulse to the printer line buffer

    reg not_busy_next;
    reg pr_busy_next;
    reg pending_next;
    reg [31:0] rd_mux;

    // bus decode; each write strobe needs its byte lane, config splits lanes
    // so the slot field can be changed without touching the own address
    wire req = wb_cyc_i && wb_stb_i;
    wire wr_now = req && ack_reg && wb_we_i; // write lands on the ack edge
    wire lane0 = wb_sel_i[0];
    wire lane1 = wb_sel_i[1];
    wire wr_sel = wr_now && lane0 && (wb_adr_i == `PASS_SEL_OFS);
    wire wr_cmd = wr_now && lane0 && (wb_adr_i == `PASS_CMD_OFS);
    wire wr_data = wr_now && lane0 && (wb_adr_i == `PASS_DATA_OFS);
    wire wr_cfg = wr_now && (wb_adr_i == `PASS_CFG_OFS);
    wire wr_istat = wr_now && lane0 && (wb_adr_i == `PASS_IRQ_STAT_OFS);
    wire wr_imask = wr_now && lane0 && (wb_adr_i == `PASS_IRQ_MASK_OFS);

    // command strobes last exactly one cycle, the ack edge of the write
    wire do_init = wr_cmd && wb_dat_i[`PASS_CMD_INIT];
    wire do_devclr = wr_cmd && wb_dat_i[`PASS_CMD_DEV_CLEAR];
    // either clear acts on the character path alike; only init deselects
    wire do_clear = do_init || do_devclr;
    // characters to an unselected adapter go nowhere
    wire do_char = wr_data && selected_reg && not_busy_reg;

    wire sel_match;
    wire stb_active;
    wire [7:0] status;
    wire [1:0] ev_set;

    // select byte decode against the own address
    // the issued byte comes straight from the write data of a select write
    pass_sel_decode #(
        .WIDTH(8)
    ) u_sel (
        .issued_i(wb_dat_i[7:0]),
        .own_i(own_addr_reg),
        .match_o(sel_match)
    );

    // strobe sequencer; a clear command aborts the character in flight
    // the character byte is latched only when the sequencer starts, so the
    // pins hold it stable through setup, strobe and hold
    pass_strobe_gen #(
        .SETUP_CYC(SETUP_CYC),
        .STB_CYC(STB_CYC),
        .HOLD_CYC(HOLD_CYC)
    ) u_stb (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .start_i(do_char),
        .abort_i(do_clear),
        .char_i(wb_dat_i[7:0]),
        .pr_data_o(pr_data_o),
        .pr_strobe_n_o(pr_strobe_n_o),
        .active_o(stb_active)
    );

    // read_status_flags image
    // bits 5..2 have no meaning here and read zero; bit 1 is inverted so
    // that a high bit in bits 1..0 flags a reason not to send
    assign status = {
        not_busy_reg,
        pr_selected_i,
        3'h0,
        1'b0,
        ~pr_ready_i,
        pr_busy_reg
    };

    // busy tracking of one character
    // completion waits for both the sequencer and the printer busy line,
    // so a printer that raises busy late still holds not-busy low; a
    // printer that never drops busy holds it low until a clear command
    always @* begin
        not_busy_next = not_busy_reg;
        pr_busy_next = pr_busy_reg;
        pending_next = pending_reg;
        if (pending_reg && !stb_active && !pr_busy_i) begin
            // printer took the character and dropped its busy line
            not_busy_next = 1'b1;
            pr_busy_next = 1'b0;
            pending_next = 1'b0;
        end
        if (do_char) begin
            not_busy_next = 1'b0;
            pr_busy_next = 1'b1;
            pending_next = 1'b1;
        end
        if (do_clear) begin
            // clear commands override a write in the same beat
            not_busy_next = 1'b1;
            pr_busy_next = 1'b0;
            pending_next = 1'b0;
        end
    end

    // events: not-busy rising, printer deselected
    // a clear command also raises not-busy, so it posts the event as well;
    // software that clears the adapter should also clear the sticky bit
    assign ev_set[`PASS_EV_NOT_BUSY] = not_busy_next && !not_busy_reg;
    assign ev_set[`PASS_EV_PR_DESEL] = pr_sel_reg && !pr_selected_i;

    // register read multiplexer
    // the mux is sampled only on the request edge, so it may glitch freely
    always @* begin
        rd_mux = 32'h00000000;
        case (wb_adr_i)
            `PASS_SEL_OFS: begin
                rd_mux = {31'h00000000, selected_reg};
            end
            `PASS_CMD_OFS: begin
                rd_mux = {29'h00000000, ien_reg, 2'h0};
            end
            `PASS_STAT_OFS: begin
                // unselected adapter leaves the bus floating high
                rd_mux = {24'h000000, selected_reg ? status : `PASS_OPEN_BUS};
            end
            `PASS_CFG_OFS: begin
                rd_mux = {20'h00000, slot_reg, own_addr_reg};
            end
            `PASS_IRQ_STAT_OFS: begin
                rd_mux = {30'h00000000, irq_stat_reg};
            end
            `PASS_IRQ_MASK_OFS: begin
                rd_mux = {30'h00000000, irq_mask_reg};
            end
            default: begin
                // unmapped and write-only addresses read zero
                rd_mux = 32'h00000000;
            end
        endcase
    end

    // bus answer: ack one cycle after the request, dropped the next
    // read data is captured with the request so it stands for the whole
    // ack cycle; a later status change shows up on the next read only
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_reg <= 1'b0;
            rdat_reg <= 32'h00000000;
        end else begin
            ack_reg <= req && !ack_reg;
            if (req && !ack_reg) begin
                rdat_reg <= rd_mux;
            end
        end
    end

    // adapter state; the bus reset acts like an initialise
    // the printer select edge detector resets low, so a printer already
    // off-line at reset gives no false deselect event
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            selected_reg <= 1'b0;
            not_busy_reg <= 1'b1;
            pr_busy_reg <= 1'b0;
            pending_reg <= 1'b0;
            ien_reg <= 1'b0;
            own_addr_reg <= `PASS_OWN_ADDR_RST;
            slot_reg <= `PASS_SLOT_RST;
            irq_stat_reg <= 2'h0;
            irq_mask_reg <= 2'h0;
            pr_sel_reg <= 1'b0;
            init_n_reg <= 1'b1;
        end else begin
            not_busy_reg <= not_busy_next;
            pr_busy_reg <= pr_busy_next;
            pending_reg <= pending_next;
            pr_sel_reg <= pr_selected_i;
            init_n_reg <= !do_clear;
            if (wr_sel) begin
                selected_reg <= sel_match;
            end
            if (do_init) begin
                selected_reg <= 1'b0;
            end
            if (wr_cmd) begin
                ien_reg <= wb_dat_i[`PASS_CMD_IEN];
            end
            if (wr_cfg && lane0) begin
                own_addr_reg <= wb_dat_i[7:0];
            end
            if (wr_cfg && lane1) begin
                slot_reg <= wb_dat_i[11:8];
            end
            if (wr_imask) begin
                irq_mask_reg <= wb_dat_i[1:0];
            end
            // write one clears; a new event in the same cycle wins
            irq_stat_reg <= (irq_stat_reg & ~(wr_istat ? wb_dat_i[1:0] : 2'h0)) | ev_set;
        end
    end

    // slot minus the offset at full width; only the low bits are kept below
    wire [3:0] slot_prio = slot_reg - `PASS_SLOT_TO_PRIO;

    // priority from slot: slots 7..10 give 3..6, else main-board 3
    // a slot outside the range falls back to the main-board level rather
    // than wrapping, so a bad config never yields a level below 3
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            level_reg <= `PASS_PRIO_MAIN;
        end else if ((slot_reg >= `PASS_SLOT_MIN) && (slot_reg <= `PASS_SLOT_MAX)) begin
            level_reg <= slot_prio[2:0];
        end else begin
            level_reg <= `PASS_PRIO_MAIN;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;
    assign pr_init_n_o = init_n_reg;
    // silent while busy even if an event stays pending
    // no further flip-flop on the request, so it drops in the same cycle
    // as the mask or enable is written
    assign irq_o = ien_reg && not_busy_reg && |(irq_stat_reg & irq_mask_reg);
    assign irq_level_o = level_reg;

endmodule // pass_adapter

/* verification/pass_monitor.sv */
// checker for the printer adapter: bus answers, strobe, status and irq
// assumes it is bound to pass_adapter and sees only its ports
`timescale 1ns/1ps
module pass_monitor #(
    parameter STB_CYC = 20
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire pr_ready_i,
    input wire pr_selected_i,
    input wire pr_strobe_n_o,
    input wire pr_init_n_o,
    input wire irq_o,
    input wire [2:0] irq_level_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // cycles the strobe has been low so far
    logic [7:0] low_cnt;
    // counter restarts whenever the strobe is released
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            low_cnt <= 8'h00;
        else
            low_cnt <= pr_strobe_n_o ? 8'h00 : low_cnt + 8'h01;
    end
    // request still waiting for its answer
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    // status read answered by a selected adapter (open bus excluded)
    sequence s_stat;
        wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 8'h0C && wb_dat_o[7:0] != 8'hFF;
    endsequence
    a_ack_after_req: assert property (s_req |=> wb_ack_o)
        else $error("no ack one cycle after request");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_status_lines: assert property (s_stat |->
        wb_dat_o[6] == $past(pr_selected_i) && wb_dat_o[1] == !$past(pr_ready_i))
        else $error("status lines do not follow printer");
    a_level_range: assert property (irq_level_o >= 3'h3 && irq_level_o <= 3'h6)
        else $error("irq level outside 3 to 6");
    a_irq_quiet_busy: assert property ($fell(pr_strobe_n_o) |-> !irq_o)
        else $error("irq while a character is in flight");
    a_init_one_cycle: assert property (!pr_init_n_o |=> pr_init_n_o)
        else $error("buffer clear pulse too long");
    a_clear_aborts: assert property (!pr_init_n_o |=> pr_strobe_n_o)
        else $error("strobe survives a clear");
    a_strobe_width: assert property (!pr_strobe_n_o |-> low_cnt < STB_CYC)
        else $error("strobe held too long");
endmodule // pass_monitor

bind pass_adapter pass_monitor #(.STB_CYC(STB_CYC)) i_mon (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pr_ready_i(pr_ready_i), .pr_selected_i(pr_selected_i),
    .pr_strobe_n_o(pr_strobe_n_o), .pr_init_n_o(pr_init_n_o),
    .irq_o(irq_o), .irq_level_o(irq_level_o));

/* verification/pass_printer_model.sv */
// printer stand-in: takes each strobed character and stays busy a while
// assumes strobe and buffer clear come from the adapter on clk_i
`timescale 1ns/1ps
module pass_printer_model #(
    parameter BUSY_CYC = 6
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire [7:0] data_i,
    input wire strobe_n_i,
    input wire init_n_i,
    output logic busy_o,
    output logic [7:0] char_o
);
    // busy cycles left after the strobe
    int left;
    // slower than the adapter hold time, so completion waits on busy
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_o <= 1'b0;
            left <= 0;
            char_o <= 8'h00;
        end else if (!init_n_i) begin
            // line buffer clear drops busy at once
            busy_o <= 1'b0;
            left <= 0;
        end else if (!strobe_n_i) begin
            busy_o <= 1'b1;
            left <= BUSY_CYC;
            char_o <= data_i;
        end else if (left > 0)
            left <= left - 1;
        else
            busy_o <= 1'b0;
    end
endmodule // pass_printer_model

/* verification/tb_top.sv */
// self-checking bench for the printer adapter with a printer stand-in
// assumes pass_adapter, pass_printer_model and the bound checker
`timescale 1ns/1ps
module tb_top;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, rdy = 1'b1, psel = 1'b1;
    logic [7:0] adr = 8'h00, own = 8'h1D, v;
    logic [31:0] wdat = 32'h0, q;
    wire [31:0] rdat;
    wire [7:0] pdata, pchar;
    wire ack, busy, strobe_n, init_n, irq;
    wire [2:0] lvl;
    int n_mismatch = 0;
    int num_checks = 0;
    int cyc_cnt = 0;

    pass_adapter #(.SETUP_CYC(1), .STB_CYC(1), .HOLD_CYC(2)) i_dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .pr_busy_i(busy), .pr_ready_i(rdy), .pr_selected_i(psel), .pr_data_o(pdata),
        .pr_strobe_n_o(strobe_n), .pr_init_n_o(init_n), .irq_o(irq), .irq_level_o(lvl));
    pass_printer_model i_prn (.clk_i(clk_i), .rst_n_i(rst_n_i), .data_i(pdata),
        .strobe_n_i(strobe_n), .init_n_i(init_n), .busy_o(busy), .char_o(pchar));

    always #25 clk_i = ~clk_i;

    // verdict and end of run
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // compare one observed value with its expectation
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // single classic cycle; ack sampled on rising edges, data taken and
    // request released at that same edge; only the hang guard ends a wait
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    // expected status flags of a selected adapter
    function automatic logic [31:0] st(input logic nb, input logic pb);
        return {24'h0, nb, psel, 4'h0, ~rdy, pb};
    endfunction

    // hang guard
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            n_mismatch++;
            conclude();
        end
    end

    initial begin
        int k;
        void'($urandom(32'h35A3));
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        // sparse select bytes leave the bus open, 8'h07 as corner
        for (int i = 0; i < 9; i++) begin
            v = (i == 0) ? 8'h07 : $urandom;
            while ($countones(v) > 3)
                v = v & (v - 8'h01);
            // sparse byte made the own address too: only the ones count stops it
            wb(1'b1, 8'h10, {20'h0, 4'h7, v});
            wb(1'b1, 8'h00, {24'h0, v});
            wb(1'b0, 8'h0C, 32'h0);
            chk("sparse status", q, 32'h0000_00FF);
        end
        // own address selects; every printer line combination
        wb(1'b1, 8'h10, {20'h0, 4'h7, own});
        wb(1'b1, 8'h00, {24'h0, own});
        wb(1'b0, 8'h00, 32'h0);
        chk("select flag", q, 32'h1);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i);
            {psel, rdy} <= i[1:0];
            wb(1'b0, 8'h0C, 32'h0);
            chk("line status", q, st(1'b1, 1'b0));
        end
        // the printer went off-line once above: sticky deselect event only
        wb(1'b0, 8'h14, 32'h0);
        chk("deselect event", q, 32'h2);
        wb(1'b1, 8'h18, 32'h1);
        wb(1'b1, 8'h04, 32'h4);
        // character then completion, initialise or device clear
        for (int c = 0; c < 3; c++) begin
            v = $urandom;
            wb(1'b1, 8'h08, {24'h0, v});
            @(negedge clk_i);
            chk("printer data", pdata, v);
            wb(1'b0, 8'h0C, 32'h0);
            chk("busy status", q, st(1'b0, 1'b1));
            chk("quiet irq", irq, 1'b0);
            if (c == 0) begin
                k = 0;
                do begin
                    wb(1'b0, 8'h0C, 32'h0);
                    k++;
                end while (q[7] !== 1'b1 && k < 60);
                chk("done status", q, st(1'b1, 1'b0));
                chk("printed char", pchar, v);
                @(negedge clk_i);
                chk("irq raised", irq, 1'b1);
                wb(1'b1, 8'h18, 32'h0);
                @(negedge clk_i);
                chk("irq masked", irq, 1'b0);
                wb(1'b1, 8'h18, 32'h1);
                wb(1'b1, 8'h14, 32'h1);
                @(negedge clk_i);
                chk("irq cleared", irq, 1'b0);
            end else begin
                wb(1'b1, 8'h04, c);
                wb(1'b0, 8'h0C, 32'h0);
                chk("after clear", q, c == 1 ? 32'hFF : st(1'b1, 1'b0));
                wb(1'b1, 8'h00, {24'h0, own});
                if (c == 1)
                    wb(1'b1, 8'h04, 32'h2);
                wb(1'b0, 8'h0C, 32'h0);
                chk("reselected", q, st(1'b1, 1'b0));
            end
        end
        // slot to priority, out-of-range slots included
        for (int s = 3; s < 12; s++) begin
            wb(1'b1, 8'h10, {20'h0, s[3:0], own});
            repeat (2) @(negedge clk_i);
            chk("irq level", lvl, (s >= 7 && s <= 10) ? s - 4 : 3);
        end
        wb(1'b0, 8'h1C, 32'h0);
        chk("unmapped read", q, 32'h0);
        conclude();
    end
endmodule // tb_top
